// [rtl/apm_regs.v]
// Power, soft mute and clock multiplier control register bank
`include "apm_map.vh"
`default_nettype none
module apm_regs #(
    parameter [7:0] RAMP_STEPS = `APM_RAMP_STEPS,
    parameter [7:0] WAKE_CYCLES = `APM_WAKE_CYCLES,
    parameter [7:0] PD_WAKE_CYCLES = `APM_PD_WAKE_CYCLES
) (
    input wire mclk,
    input wire nrst,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire mult_locked_raw,
    input wire clock_error_raw,
    output reg [7:0] rdata_ff,
    output reg rvalid_ff,
    output reg core_reset_ff,
    output reg core_run_ff,
    output reg standby_ff,
    output reg powerdown_ff,
    output reg charge_pump_on_ff,
    output reg mult_enable_ff,
    output reg use_mult_clock_ff,
    output reg [7:0] left_level_ff,
    output reg [7:0] right_level_ff,
    output reg left_silent_ff,
    output reg right_silent_ff
);
    localparam [3:0] ST_RUN = 4'b0001;
    localparam [3:0] ST_STANDBY = 4'b0010;
    localparam [3:0] ST_POWERDOWN = 4'b0100;
    localparam [3:0] ST_WAKE = 4'b1000;

    reg core_reset_req_ff;
    reg standby_req_ff;
    reg powerdown_req_ff;
    reg left_mute_ff;
    reg right_mute_ff;
    reg mult_en_req_ff;
    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [7:0] wake_cnt_ff;
    reg [7:0] nxt_wake_cnt;
    reg [7:0] nxt_rdata;
    wire locked_sync;
    wire clk_err_sync;
    wire lock_flag;
    wire [7:0] left_level;
    wire [7:0] right_level;
    wire left_silent;
    wire right_silent;
    wire running;
    wire sel_power;
    wire sel_mute;
    wire sel_clock;
    wire wr_power;
    wire wr_mute;
    wire wr_clock;
    wire in_run;
    wire in_standby;
    wire in_powerdown;
    wire standby_cause;

    // Lock and clock error come from other clock domains
    apm_sync2 u_sync_lock (
        .mclk(mclk),
        .nrst(nrst),
        .din(mult_locked_raw),
        .dout(locked_sync)
    );

    apm_sync2 u_sync_err (
        .mclk(mclk),
        .nrst(nrst),
        .din(clock_error_raw),
        .dout(clk_err_sync)
    );

    // Flag is inverted lock, forced high when multiplier is off
    assign lock_flag = ~(locked_sync & mult_en_req_ff);

    // Offset decode shared by the write strobes
    assign sel_power = (addr == `APM_OFS_POWER);
    assign sel_mute = (addr == `APM_OFS_MUTE);
    assign sel_clock = (addr == `APM_OFS_CLOCK);
    assign wr_power = wr_en && sel_power;
    assign wr_mute = wr_en && sel_mute;
    assign wr_clock = wr_en && sel_clock;

    // Power request bits; reserved bits are not stored
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_reset_req_ff <= `APM_RST_CORE_RESET;
            standby_req_ff <= `APM_RST_STANDBY;
            powerdown_req_ff <= `APM_RST_POWERDOWN;
        end else if (wr_power) begin
            core_reset_req_ff <= wdata[`APM_BIT_CORE_RESET];
            standby_req_ff <= wdata[`APM_BIT_STANDBY];
            powerdown_req_ff <= wdata[`APM_BIT_POWERDOWN];
        end
    end

    // Soft mute requests
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            left_mute_ff <= `APM_RST_MUTE;
            right_mute_ff <= `APM_RST_MUTE;
        end else if (wr_mute) begin
            left_mute_ff <= wdata[`APM_BIT_LEFT_MUTE];
            right_mute_ff <= wdata[`APM_BIT_RIGHT_MUTE];
        end
    end

    // Multiplier enable; the lock flag bit is read-only and ignored here
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            mult_en_req_ff <= `APM_RST_MULT_EN;
        else if (wr_clock)
            mult_en_req_ff <= wdata[`APM_BIT_MULT_EN];
    end

    // Read mux; reserved bits read zero, unmapped offsets read zero
    always @* begin
        nxt_rdata = 8'h00;
        case (addr)
            `APM_OFS_POWER: begin
                nxt_rdata[`APM_BIT_CORE_RESET] = core_reset_req_ff;
                nxt_rdata[`APM_BIT_STANDBY] = standby_req_ff;
                nxt_rdata[`APM_BIT_POWERDOWN] = powerdown_req_ff;
            end
            `APM_OFS_MUTE: begin
                nxt_rdata[`APM_BIT_LEFT_MUTE] = left_mute_ff;
                nxt_rdata[`APM_BIT_RIGHT_MUTE] = right_mute_ff;
            end
            `APM_OFS_CLOCK: begin
                nxt_rdata[`APM_BIT_LOCK] = lock_flag;
                nxt_rdata[`APM_BIT_MULT_EN] = mult_en_req_ff;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    // Read answer one cycle after the strobe; data holds until the next read
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            rvalid_ff <= 1'b0;
        else
            rvalid_ff <= rd_en;
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            rdata_ff <= 8'h00;
        else if (rd_en)
            rdata_ff <= nxt_rdata;
    end

    // Clock errors force the same standby as the request bit
    assign standby_cause = standby_req_ff || clk_err_sync;

    // Power state machine; powerdown is checked first in all four states, illegal codes go to standby
    always @* begin
        nxt_state = state_ff;
        nxt_wake_cnt = wake_cnt_ff;
        case (state_ff)
            ST_RUN: begin
                if (powerdown_req_ff)
                    nxt_state = ST_POWERDOWN;
                else if (standby_cause)
                    nxt_state = ST_STANDBY;
            end
            ST_STANDBY: begin
                if (powerdown_req_ff)
                    nxt_state = ST_POWERDOWN;
                else if (!standby_cause) begin
                    nxt_state = ST_WAKE;
                    nxt_wake_cnt = WAKE_CYCLES;
                end
            end
            // Leaving powerdown with no standby cause takes the longer restart of the charge pump
            ST_POWERDOWN: begin
                if (!powerdown_req_ff) begin
                    if (standby_cause)
                        nxt_state = ST_STANDBY;
                    else begin
                        nxt_state = ST_WAKE;
                        nxt_wake_cnt = PD_WAKE_CYCLES;
                    end
                end
            end
            // A new low power request aborts a restart in progress
            ST_WAKE: begin
                if (powerdown_req_ff)
                    nxt_state = ST_POWERDOWN;
                else if (standby_cause)
                    nxt_state = ST_STANDBY;
                else if (wake_cnt_ff <= 8'h01)
                    nxt_state = ST_RUN;
                else
                    nxt_wake_cnt = wake_cnt_ff - 8'h01;
            end
            default: begin
                nxt_state = ST_STANDBY;
            end
        endcase
    end

    // Reset starts the short standby restart sequence
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_WAKE;
            wake_cnt_ff <= WAKE_CYCLES;
        end else begin
            state_ff <= nxt_state;
            wake_cnt_ff <= nxt_wake_cnt;
        end
    end

    assign in_run = (state_ff == ST_RUN);
    assign in_standby = (state_ff == ST_STANDBY);
    assign in_powerdown = (state_ff == ST_POWERDOWN);

    // Core runs only in normal operation with core reset released
    assign running = in_run && !core_reset_req_ff;

    // Both channels ramp only while the core runs
    apm_ramp #(
        .STEPS(RAMP_STEPS)
    ) u_ramp_left (
        .mclk(mclk),
        .nrst(nrst),
        .mute_req(left_mute_ff),
        .run(running),
        .level(left_level),
        .silent(left_silent)
    );

    apm_ramp #(
        .STEPS(RAMP_STEPS)
    ) u_ramp_right (
        .mclk(mclk),
        .nrst(nrst),
        .mute_req(right_mute_ff),
        .run(running),
        .level(right_level),
        .silent(right_silent)
    );

    // Power state outputs
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_reset_ff <= `APM_RST_CORE_RESET;
            core_run_ff <= 1'b0;
            standby_ff <= 1'b0;
            powerdown_ff <= 1'b0;
            charge_pump_on_ff <= 1'b1;
        end else begin
            core_reset_ff <= core_reset_req_ff;
            core_run_ff <= running;
            standby_ff <= in_standby;
            powerdown_ff <= in_powerdown;
            charge_pump_on_ff <= !in_powerdown;
        end
    end

    // Clock source follows the multiplier enable
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mult_enable_ff <= `APM_RST_MULT_EN;
            use_mult_clock_ff <= `APM_RST_MULT_EN;
        end else begin
            mult_enable_ff <= mult_en_req_ff;
            use_mult_clock_ff <= mult_en_req_ff;
        end
    end

    // Ramp levels registered once more for the output pins
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            left_level_ff <= 8'h00;
            right_level_ff <= 8'h00;
            left_silent_ff <= 1'b1;
            right_silent_ff <= 1'b1;
        end else begin
            left_level_ff <= left_level;
            right_level_ff <= right_level;
            left_silent_ff <= left_silent;
            right_silent_ff <= right_silent;
        end
    end
endmodule
`default_nettype wire

// [rtl/apm_map.vh]
// Register offsets, field positions and reset values of the power and mode control bank
`ifndef APM_MAP_VH
`define APM_MAP_VH
`define APM_OFS_POWER 8'h02
`define APM_OFS_MUTE 8'h03
`define APM_OFS_CLOCK 8'h04
`define APM_BIT_CORE_RESET 7
`define APM_BIT_STANDBY 4
`define APM_BIT_POWERDOWN 0
`define APM_BIT_LEFT_MUTE 4
`define APM_BIT_RIGHT_MUTE 0
`define APM_BIT_LOCK 4
`define APM_BIT_MULT_EN 0
`define APM_RST_CORE_RESET 1'b1
`define APM_RST_STANDBY 1'b0
`define APM_RST_POWERDOWN 1'b0
`define APM_RST_MUTE 1'b0
`define APM_RST_MULT_EN 1'b1
`define APM_RAMP_STEPS 8'h40
`define APM_WAKE_CYCLES 8'h10
`define APM_PD_WAKE_CYCLES 8'h40
`endif

// [rtl/apm_sync2.v]
// Two flip-flop synchroniser for one level
`default_nettype none
module apm_sync2 (
    input wire mclk,
    input wire nrst,
    input wire din,
    output wire dout
);
    reg stage1_ff;
    reg stage2_ff;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= din;
            stage2_ff <= stage1_ff;
        end
    end
    assign dout = stage2_ff;
endmodule
`default_nettype wire

// [rtl/apm_ramp.v]
// Soft mute volume ramp for one channel
`include "apm_map.vh"
`default_nettype none
module apm_ramp #(
    parameter [7:0] STEPS = `APM_RAMP_STEPS
) (
    input wire mclk,
    input wire nrst,
    input wire mute_req,
    input wire run,
    output wire [7:0] level,
    output wire silent
);
    reg [7:0] level_ff;
    reg [7:0] nxt_level;
    always @* begin
        nxt_level = level_ff;
        if (!run)
            nxt_level = 8'h00;
        else if (mute_req && level_ff != 8'h00)
            nxt_level = level_ff - 8'h01;
        else if (!mute_req && level_ff != STEPS)
            nxt_level = level_ff + 8'h01;
    end
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            level_ff <= 8'h00;
        else
            level_ff <= nxt_level;
    end
    assign level = level_ff;
    assign silent = (level_ff == 8'h00);
endmodule
`default_nettype wire

// [sim/apm_host.sv]
// Host model that drives the register port of the control bank
`default_nettype none
module apm_host (
    input wire logic mclk,
    input wire logic [7:0] rdata_ff,
    input wire logic rvalid_ff,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // Released lines show the inverse so stale values never pass
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        v = (rvalid_ff === 1'b1) ? rdata_ff : 8'hxx;
        #1;
    endtask
endmodule
`default_nettype wire

// [sim/apm_regs_sva.sv]
// Concurrent checks on the ports of the control bank
`default_nettype none
module apm_regs_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata_ff,
    input wire logic rvalid_ff,
    input wire logic core_reset_ff,
    input wire logic core_run_ff,
    input wire logic standby_ff,
    input wire logic powerdown_ff,
    input wire logic charge_pump_on_ff,
    input wire logic mult_enable_ff,
    input wire logic use_mult_clock_ff,
    input wire logic [7:0] left_level_ff,
    input wire logic [7:0] right_level_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    AST_RD_ZERO: assert property (rd_en |=> rvalid_ff && rdata_ff[6:5] == 2'h0
        && rdata_ff[3:1] == 3'h0) else $error("read answer late or reserved bits set");
    AST_PD_PUMP: assert property (powerdown_ff |-> !charge_pump_on_ff)
        else $error("charge pump on in powerdown");
    AST_PD_WINS: assert property (powerdown_ff |-> !standby_ff)
        else $error("standby shown with powerdown");
    AST_SB_PUMP: assert property (standby_ff |-> charge_pump_on_ff)
        else $error("charge pump off in standby");
    AST_CORE_RUN: assert property (core_run_ff |-> !core_reset_ff && !standby_ff
        && !powerdown_ff) else $error("core runs while held");
    AST_CLK_SEL: assert property ($fell(mult_enable_ff) |-> ##[0:2] !use_mult_clock_ff)
        else $error("clock not switched to pin");
    AST_LOCK_OFF: assert property (rd_en && addr == 8'h04
        |=> rdata_ff[4] || mult_enable_ff) else $error("lock shown while disabled");
    AST_PD_BOTH: assert property (wr_en && addr == 8'h02 && wdata[0] && wdata[4]
        |-> ##3 powerdown_ff && !standby_ff) else $error("both requests gave no powerdown");
    AST_L_STEP: assert property (left_level_ff > $past(left_level_ff)
        |-> left_level_ff == $past(left_level_ff) + 8'h01) else $error("left ramp jumped");
    AST_R_STEP: assert property (right_level_ff > $past(right_level_ff)
        |-> right_level_ff == $past(right_level_ff) + 8'h01) else $error("right ramp jumped");
    cover property (powerdown_ff);
    cover property (standby_ff && !powerdown_ff);
    cover property ($fell(use_mult_clock_ff));
endmodule
bind apm_regs apm_regs_chk i_chk (.*);
`default_nettype wire

// [sim/amp_power_mode_control_regs_tb.sv]
// Self-checking bench of the power and mode control bank
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module amp_power_mode_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, nrst, wr_en, rd_en, mult_locked_raw, clock_error_raw, rvalid_ff;
    logic [7:0] addr, wdata, rdata_ff, left_level_ff, right_level_ff, d;
    logic core_reset_ff, core_run_ff, standby_ff, powerdown_ff, charge_pump_on_ff;
    logic mult_enable_ff, use_mult_clock_ff, left_silent_ff, right_silent_ff;
    int fail_count = 0;
    int checked = 0;
    apm_regs #(.RAMP_STEPS(8'h04), .WAKE_CYCLES(8'h02), .PD_WAKE_CYCLES(8'h04)) i_dut (.*);
    apm_host i_host (.*);
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (2000) @(posedge mclk);
        fail_count++;
        complete_run;
    end
    initial begin
        nrst = 1'b0;
        mult_locked_raw = 1'b0;
        clock_error_raw = 1'b0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        i_host.rd(8'h02, d);
        `CHK("power", 8'h80, d)
        i_host.rd(8'h03, d);
        `CHK("mute", 8'h00, d)
        i_host.rd(8'h04, d);
        `CHK("clock", 8'h11, d)
        mult_locked_raw <= 1'b1;
        cyc(4);
        i_host.rd(8'h04, d);
        `CHK("clock", 8'h01, d)
        i_host.wr(8'h02, 8'h00);
        cyc(16);
        `CHK("core_run", 1'b1, core_run_ff)
        `CHK("left_level", 8'h04, left_level_ff)
        i_host.wr(8'h03, 8'hff);
        i_host.rd(8'h03, d);
        `CHK("mute", 8'h11, d)
        cyc(8);
        `CHK("left_level", 8'h00, left_level_ff)
        `CHK("right_level", 8'h00, right_level_ff)
        i_host.wr(8'h03, 8'h10);
        cyc(8);
        `CHK("left_level", 8'h00, left_level_ff)
        `CHK("right_level", 8'h04, right_level_ff)
        `CHK("left_silent", 1'b1, left_silent_ff)
        `CHK("right_silent", 1'b0, right_silent_ff)
        i_host.wr(8'h03, 8'h00);
        cyc(8);
        `CHK("left_level", 8'h04, left_level_ff)
        i_host.wr(8'h02, 8'hff);
        i_host.rd(8'h02, d);
        `CHK("power", 8'h91, d)
        `CHK("powerdown", 1'b1, powerdown_ff)
        `CHK("standby", 1'b0, standby_ff)
        `CHK("pump", 1'b0, charge_pump_on_ff)
        `CHK("core_reset", 1'b1, core_reset_ff)
        i_host.wr(8'h02, 8'h10);
        cyc(3);
        `CHK("standby", 1'b1, standby_ff)
        `CHK("pump", 1'b1, charge_pump_on_ff)
        `CHK("left_level", 8'h00, left_level_ff)
        i_host.wr(8'h02, 8'h00);
        cyc(12);
        `CHK("core_run", 1'b1, core_run_ff)
        clock_error_raw <= 1'b1;
        cyc(4);
        `CHK("standby", 1'b1, standby_ff)
        clock_error_raw <= 1'b0;
        cyc(12);
        `CHK("core_run", 1'b1, core_run_ff)
        i_host.wr(8'h02, 8'h01);
        cyc(3);
        `CHK("powerdown", 1'b1, powerdown_ff)
        i_host.wr(8'h02, 8'h00);
        cyc(4);
        `CHK("core_run", 1'b0, core_run_ff)
        cyc(2);
        `CHK("core_run", 1'b1, core_run_ff)
        i_host.wr(8'h04, 8'h00);
        cyc(3);
        i_host.rd(8'h04, d);
        `CHK("clock", 8'h10, d)
        `CHK("clk_sel", 1'b0, use_mult_clock_ff)
        `CHK("mult_en", 1'b0, mult_enable_ff)
        i_host.wr(8'h04, 8'hff);
        cyc(4);
        i_host.rd(8'h04, d);
        `CHK("clock", 8'h01, d)
        `CHK("clk_sel", 1'b1, use_mult_clock_ff)
        i_host.rd(8'h05, d);
        `CHK("unmapped", 8'h00, d)
        nrst <= 1'b0;
        cyc(2);
        `CHK("core_reset", 1'b1, core_reset_ff)
        `CHK("core_run", 1'b0, core_run_ff)
        nrst <= 1'b1;
        i_host.rd(8'h02, d);
        `CHK("power", 8'h80, d)
        complete_run;
    end
endmodule
`default_nettype wire
